/* design/spe_eeprom_front.v */
// Serial EEPROM pin front end with array, status and self-timed write
`timescale 1ns/1ps
`default_nettype none

`include "spe_map.vh"

module spe_eeprom_front #(
  parameter ADDR_W = `SPE_ADDR_W,
  parameter PAGE_DEPTH = `SPE_PAGE_DEPTH,
  parameter PAGE_PTR_W = 4,
  parameter [31:0] WRITE_CYCLES = `SPE_WRITE_CYCLES
)
(
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Serial pins, asynchronous to core_clk
  input wire csN,
  input wire sck,
  input wire si,
  input wire wpN,
  input wire holdN,
  // Serial output, three-state
  output reg soOut,
  output reg soOe,
  // Write cycle in progress
  output reg writeBusy
);
  localparam DEPTH = 1 << ADDR_W;
  localparam FIFO_W = ADDR_W + 8;
  localparam CNT_W = `SPE_WCNT_W;
  localparam [CNT_W-1:0] CNT_LOAD = WRITE_CYCLES[CNT_W-1:0] - 1'b1;
  localparam [7:0] STATUS_RST = `SPE_STATUS_RESET;
  localparam [6:0] ST_CMD = 7'b000_0001;
  localparam [6:0] ST_ADDR = 7'b000_0010;
  localparam [6:0] ST_READ = 7'b000_0100;
  localparam [6:0] ST_WRITE = 7'b000_1000;
  localparam [6:0] ST_RDSR = 7'b001_0000;
  localparam [6:0] ST_WRSR = 7'b010_0000;
  localparam [6:0] ST_IGNORE = 7'b100_0000;
  // Block protect coverage of an address
  function isProtected;
    input [ADDR_W-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        `SPE_BP_QUARTER: isProtected = (a[ADDR_W-1:ADDR_W-2] == 2'b11);
        `SPE_BP_HALF: isProtected = a[ADDR_W-1];
        `SPE_BP_ALL: isProtected = 1'b1;
        default: isProtected = 1'b0;
      endcase
    end
  endfunction
  // Pin synchronisers: stage 1 feeds only stage 2
  reg csS1_r, csS2_r, csS3_r;
  reg sckS1_r, sckS2_r, sckS3_r;
  reg siS1_r, siS2_r;
  reg wpS1_r, wpS2_r, wpS3_r;
  reg holdS1_r, holdS2_r;
  reg [7:0] mem [0:DEPTH-1];
  reg [6:0] state_r;
  reg [2:0] bitCnt_r;
  reg [7:0] inShift_r;
  reg [7:0] outShift_r;
  reg [7:0] addrHi_r;
  reg addrSecond_r;
  reg isRead_r;
  reg [ADDR_W-1:0] addr_r;
  reg selected_r;
  reg armed_r;
  reg paused_r;
  reg wel_r;
  reg protectPinEnableBit_r;
  reg [1:0] bp_r;
  reg [7:0] wrsrByte_r;
  reg wrsrHave_r;
  reg wrsrAbort_r;
  reg pushedAny_r;
  reg [CNT_W-1:0] wcnt_r;
  wire csFall = csS3_r & ~csS2_r;
  wire csRise = ~csS3_r & csS2_r;
  wire active = selected_r & ~paused_r & ~csS2_r;
  wire sckRise = active & sckS2_r & ~sckS3_r;
  wire sckFall = active & ~sckS2_r & sckS3_r;
  wire wpFall = wpS3_r & ~wpS2_r;
  wire [7:0] shiftIn = {inShift_r[6:0], siS2_r};
  wire byteDone = (bitCnt_r == 3'd7);
  wire [7:0] statusByte = {protectPinEnableBit_r, 3'b000, bp_r, wel_r, writeBusy};
  wire wpBlocks = protectPinEnableBit_r & ~wpS2_r;
  wire [ADDR_W-1:0] addrInc = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [15:0] addrFull = {addrHi_r, shiftIn};
  wire [ADDR_W-1:0] addrNew = addrFull[ADDR_W-1:0];
  // Page buffer between the serial side and the array
  wire fifoInReady;
  wire fifoOutValid;
  wire [FIFO_W-1:0] fifoOutData;
  wire pushValid = sckRise & (state_r == ST_WRITE) & byteDone & wel_r &
    ~isProtected(addr_r, bp_r);
  wire popReady = writeBusy;
  spe_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(PAGE_DEPTH),
    .PTR_W(PAGE_PTR_W)
  ) pageBuf (
    .core_clk(core_clk),
    .resetn(resetn),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData({addr_r, shiftIn}),
    .outValid(fifoOutValid),
    .outReady(popReady),
    .outData(fifoOutData)
  );
  // Array writes drain the page buffer only during the write cycle
  always @(posedge core_clk)
  begin
    if (fifoOutValid && popReady)
      mem[fifoOutData[FIFO_W-1:8]] <= fifoOutData[7:0];
  end
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csS3_r <= 1'b1;
      sckS1_r <= 1'b0;
      sckS2_r <= 1'b0;
      sckS3_r <= 1'b0;
      siS1_r <= 1'b0;
      siS2_r <= 1'b0;
      wpS1_r <= 1'b1;
      wpS2_r <= 1'b1;
      wpS3_r <= 1'b1;
      holdS1_r <= 1'b1;
      holdS2_r <= 1'b1;
    end
    else
    begin
      csS1_r <= csN;
      csS2_r <= csS1_r;
      csS3_r <= csS2_r;
      sckS1_r <= sck;
      sckS2_r <= sckS1_r;
      sckS3_r <= sckS2_r;
      siS1_r <= si;
      siS2_r <= siS1_r;
      wpS1_r <= wpN;
      wpS2_r <= wpS1_r;
      wpS3_r <= wpS2_r;
      holdS1_r <= holdN;
      holdS2_r <= holdS1_r;
    end
  end
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IGNORE;
      bitCnt_r <= 3'd0;
      inShift_r <= 8'h00;
      outShift_r <= 8'h00;
      addrHi_r <= 8'h00;
      addrSecond_r <= 1'b0;
      isRead_r <= 1'b0;
      addr_r <= {ADDR_W{1'b0}};
      selected_r <= 1'b0;
      armed_r <= 1'b0;
      paused_r <= 1'b0;
      wel_r <= 1'b0;
      protectPinEnableBit_r <= STATUS_RST[`SPE_ST_PE];
      bp_r <= `SPE_BP_NONE;
      wrsrByte_r <= 8'h00;
      wrsrHave_r <= 1'b0;
      wrsrAbort_r <= 1'b0;
      pushedAny_r <= 1'b0;
      wcnt_r <= {CNT_W{1'b0}};
      writeBusy <= 1'b0;
      soOut <= 1'b0;
      soOe <= 1'b0;
    end
    else
    begin
      // A selection counts only after chip select was seen high
      if (csS2_r)
        armed_r <= 1'b1;
      if (csFall && armed_r)
      begin
        selected_r <= 1'b1;
        state_r <= ST_CMD;
        bitCnt_r <= 3'd0;
        paused_r <= 1'b0;
        pushedAny_r <= 1'b0;
        wrsrHave_r <= 1'b0;
        wrsrAbort_r <= 1'b0;
      end
      if (csRise)
      begin
        selected_r <= 1'b0;
        state_r <= ST_IGNORE;
        bitCnt_r <= 3'd0;
        addrSecond_r <= 1'b0;
        paused_r <= 1'b0;
        if (selected_r && pushedAny_r && wel_r)
        begin
          writeBusy <= 1'b1;
          wcnt_r <= CNT_LOAD;
        end
        else if (selected_r && wrsrHave_r && wel_r && !wrsrAbort_r && !wpBlocks)
        begin
          protectPinEnableBit_r <= wrsrByte_r[`SPE_ST_PE];
          bp_r <= wrsrByte_r[`SPE_ST_BP_HI:`SPE_ST_BP_LO];
          writeBusy <= 1'b1;
          wcnt_r <= CNT_LOAD;
        end
      end
      // Pause entry and exit only while the clock is low
      if (selected_r && !csS2_r && !sckS2_r)
        paused_r <= ~holdS2_r;
      // Protect pin falling before the cycle starts cancels a status write
      if (selected_r && !csS2_r && wpFall && protectPinEnableBit_r &&
          (state_r == ST_WRSR || wrsrHave_r))
        wrsrAbort_r <= 1'b1;
      // Self-timed write cycle
      if (writeBusy)
      begin
        if (wcnt_r == {CNT_W{1'b0}})
        begin
          writeBusy <= 1'b0;
          wel_r <= 1'b0;
        end
        else
          wcnt_r <= wcnt_r - 1'b1;
      end
      // Serial input sampled on rising edges
      if (sckRise)
      begin
        inShift_r <= shiftIn;
        bitCnt_r <= bitCnt_r + 3'd1;
        if (byteDone)
        begin
          case (state_r)
            ST_CMD:
            begin
              if (shiftIn == `SPE_OP_RD_STATUS)
              begin
                state_r <= ST_RDSR;
                outShift_r <= statusByte;
              end
              else if (writeBusy)
                state_r <= ST_IGNORE;
              else if (shiftIn == `SPE_OP_READ || shiftIn == `SPE_OP_WRITE)
              begin
                state_r <= ST_ADDR;
                isRead_r <= (shiftIn == `SPE_OP_READ);
                addrSecond_r <= 1'b0;
              end
              else if (shiftIn == `SPE_OP_WR_STATUS)
                state_r <= ST_WRSR;
              else
              begin
                if (shiftIn == `SPE_OP_WR_ENABLE)
                  wel_r <= 1'b1;
                if (shiftIn == `SPE_OP_WR_DISABLE)
                  wel_r <= 1'b0;
                state_r <= ST_IGNORE;
              end
            end
            ST_ADDR:
            begin
              addrSecond_r <= 1'b1;
              addrHi_r <= shiftIn;
              if (addrSecond_r)
              begin
                addr_r <= isRead_r ? addrNew + {{(ADDR_W-1){1'b0}}, 1'b1} : addrNew;
                outShift_r <= mem[addrNew];
                state_r <= isRead_r ? ST_READ : ST_WRITE;
              end
            end
            ST_READ:
            begin
              outShift_r <= mem[addr_r];
              addr_r <= addrInc;
            end
            ST_RDSR:
              outShift_r <= statusByte;
            ST_WRITE:
            begin
              if (pushValid && fifoInReady)
                pushedAny_r <= 1'b1;
              addr_r <= addrInc;
            end
            ST_WRSR:
            begin
              wrsrByte_r <= shiftIn;
              wrsrHave_r <= 1'b1;
              state_r <= ST_IGNORE;
            end
            default:
              state_r <= ST_IGNORE;
          endcase
        end
      end
      // Serial output launched on falling edges
      if (sckFall && (state_r == ST_READ || state_r == ST_RDSR))
      begin
        soOut <= outShift_r[7];
        outShift_r <= {outShift_r[6:0], 1'b0};
      end
      // Output drives only while selected, unpaused and in a read phase
      soOe <= selected_r & ~csS2_r & ~paused_r & ~(~holdS2_r & ~sckS2_r) &
        (state_r == ST_READ || state_r == ST_RDSR);
    end
  end

endmodule

`default_nettype wire

/* design/spe_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spe_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter PTR_W = 4
)
(
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtr_r;
  reg [PTR_W-1:0] rdPtr_r;
  reg [PTR_W:0] count_r;
  wire doPush;
  wire doPop;

  assign inReady = (count_r != DEPTH[PTR_W:0]);
  assign outValid = (count_r != {(PTR_W+1){1'b0}});
  assign outData = store[rdPtr_r];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always @(posedge core_clk)
  begin
    if (doPush)
      store[wrPtr_r] <= inData;
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_r <= {PTR_W{1'b0}};
      rdPtr_r <= {PTR_W{1'b0}};
      count_r <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr_r <= (wrPtr_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= (rdPtr_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rdPtr_r + 1'b1;
      if (doPush && !doPop)
        count_r <= count_r + 1'b1;
      else if (doPop && !doPush)
        count_r <= count_r - 1'b1;
    end
  end

endmodule

`default_nettype wire

/* design/spe_map.vh */
// Constants for the serial EEPROM pin front end
`ifndef SPE_MAP_VH
`define SPE_MAP_VH

// Instruction codes
`define SPE_OP_WR_STATUS 8'h01
`define SPE_OP_WRITE 8'h02
`define SPE_OP_READ 8'h03
`define SPE_OP_WR_DISABLE 8'h04
`define SPE_OP_RD_STATUS 8'h05
`define SPE_OP_WR_ENABLE 8'h06

// Status byte field positions
`define SPE_ST_BUSY 0
`define SPE_ST_WEL 1
`define SPE_ST_BP_LO 2
`define SPE_ST_BP_HI 3
`define SPE_ST_PE 7
`define SPE_STATUS_RESET 8'h00

// Block protect codes
`define SPE_BP_NONE 2'b00
`define SPE_BP_QUARTER 2'b01
`define SPE_BP_HALF 2'b10
`define SPE_BP_ALL 2'b11

// Array geometry
`define SPE_ADDR_W 10
`define SPE_PAGE_DEPTH 16

// Self-timed write cycle
`define SPE_CLK_MHZ 40
`define SPE_WRITE_TIME_US 5000
`define SPE_WRITE_CYCLES (`SPE_WRITE_TIME_US * `SPE_CLK_MHZ)
`define SPE_WCNT_W 18

`endif

/* design/unused_placeholder_none.v */
// Intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/spe_front_props.sv */
// Port checks for the serial EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module spe_front_props #(
  parameter [31:0] WRITE_CYCLES = 200000
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic wpN,
  input wire logic holdN,
  // Outputs
  input wire logic soOut,
  input wire logic soOe,
  input wire logic writeBusy
);
  localparam int BUSY_MAX = WRITE_CYCLES + 8;
  logic [31:0] busyCnt_r;
  logic [7:0] riseCnt_r;
  logic sckPrev_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Busy length and serial clock rises within one selection
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busyCnt_r <= 32'h0000_0000;
      riseCnt_r <= 8'h00;
      sckPrev_r <= 1'b0;
    end
    else
    begin
      busyCnt_r <= writeBusy ? busyCnt_r + 32'h0000_0001 : 32'h0000_0000;
      sckPrev_r <= sck;
      // Keep the count until the output has been let go after deselect
      if (csN && !soOe)
        riseCnt_r <= 8'h00;
      else if (sck && !sckPrev_r && riseCnt_r != 8'hFF)
        riseCnt_r <= riseCnt_r + 8'h01;
    end
  end
  property p_deselect;
    csN [*6] |-> !soOe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("so driven while deselected");
  property p_pause;
    !holdN [*6] |-> !soOe;
  endproperty
  a_pause: assert property (p_pause) else $error("so driven while paused");
  property p_oe_sel;
    $rose(soOe) |-> !csN && holdN;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("so enabled while not selected");
  property p_opcode;
    soOe |-> riseCnt_r >= 8'h08;
  endproperty
  a_opcode: assert property (p_opcode) else $error("so enabled before opcode");
  property p_so_hold;
    sck && $past(sck) && $past(sck, 2) && soOe && $past(soOe) |-> $stable(soOut);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("so changed while clock high");
  property p_busy_max;
    writeBusy |-> busyCnt_r < BUSY_MAX;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
  property p_busy_start;
    $rose(writeBusy) |-> csN;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write began while selected");
  property p_reset_quiet;
    $rose(resetn) |-> !soOe && !writeBusy;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  c_read: cover property ($rose(soOe));
  c_write: cover property ($fell(writeBusy));
  c_pause: cover property (!holdN && !csN);
endmodule
`default_nettype wire

/* tb/spe_master.sv */
// SPI master model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module spe_master (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN,
  input wire logic soOut
);
  logic [7:0] txq[$];
  logic [7:0] rxByte;
  logic mode3 = 1'b0;
  event got;
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
  end
  // One frame of txq; bytes from index skip on are reported
  task automatic run(input int skip, input bit pause);
    sck <= mode3;
    @(posedge core_clk);
    csN <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < txq.size(); k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sck <= 1'b0;
        si <= txq[k][i];
        repeat (4) @(posedge core_clk);
        if (pause && k == skip && i == 4)
        begin
          holdN <= 1'b0;
          repeat (12) @(posedge core_clk);
          holdN <= 1'b1;
          repeat (4) @(posedge core_clk);
        end
        sck <= 1'b1;
        repeat (2) @(posedge core_clk);
        rxByte[i] = soOut;
        repeat (2) @(posedge core_clk);
      end
      if (k >= skip)
        -> got;
    end
    sck <= mode3;
    repeat (4) @(posedge core_clk);
    csN <= 1'b1;
    // Released data line shows the inverse
    si <= ~si;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Top testbench for the serial EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int WCYC = 50;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wpN = 1'b1;
  logic csN, sck, si, holdN, soOut, soOe, writeBusy;
  wire logic soLine = soOe ? soOut : 1'bz;
  logic [15:0] expq[$];
  logic [7:0] addr, seen;
  logic [7:0] dat[16];
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  spe_eeprom_front #(.WRITE_CYCLES(WCYC)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .csN(csN), .sck(sck), .si(si), .wpN(wpN), .holdN(holdN), .soOut(soOut),
    .soOe(soOe), .writeBusy(writeBusy));
  spe_master u_master (.core_clk(core_clk), .csN(csN), .sck(sck), .si(si),
    .holdN(holdN), .soOut(soLine));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b[$]);
    u_master.txq = b;
    u_master.run(99, 1'b0);
    for (int n = 0; writeBusy !== 1'b0 && n < 400; n++)
      @(posedge core_clk);
    check({7'h00, writeBusy}, 8'h00);
  endtask
  // Status read; the upper byte masks what is compared
  task automatic status(input logic [15:0] me);
    expq.push_back(me);
    u_master.txq = {8'h05, 8'h00};
    u_master.run(1, 1'b0);
  endtask
  task automatic wrsr(input logic [7:0] v);
    cmd({8'h06});
    cmd({8'h01, v});
  endtask
  always @(u_master.got)
  begin
    seen = expq[0][15:8] & u_master.rxByte;
    check(seen, expq[0][7:0]);
    void'(expq.pop_front());
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    void'($urandom(1827));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    addr = $urandom;
    addr[3:0] = 4'h0;
    cmd({8'h06});
    u_master.txq = {8'h02, 8'h02, addr};
    for (int i = 0; i < 16; i++)
    begin
      dat[i] = $urandom;
      u_master.txq.push_back(dat[i]);
    end
    cmd(u_master.txq);
    u_master.mode3 = 1'b1;
    u_master.txq = {8'h03, 8'h02, addr};
    for (int i = 0; i < 16; i++)
    begin
      u_master.txq.push_back(8'h00);
      expq.push_back({8'hFF, dat[i]});
    end
    u_master.run(3, 1'b1);
    u_master.mode3 = 1'b0;
    cmd({8'h06});
    status({8'hFF, 8'h02});
    cmd({8'h04});
    status({8'h02, 8'h00});
    wpN <= 1'b0;
    wrsr(8'h0C);
    status({8'h8D, 8'h0C});
    cmd({8'h06});
    cmd({8'h02, 8'h02, addr, ~dat[0]});
    expq.push_back({8'hFF, dat[0]});
    u_master.txq = {8'h03, 8'h02, addr, 8'h00};
    u_master.run(3, 1'b0);
    wpN <= 1'b1;
    wrsr(8'h80);
    status({8'h8D, 8'h80});
    wpN <= 1'b0;
    wrsr(8'h00);
    status({8'h8D, 8'h80});
    wpN <= 1'b1;
    cmd({8'h06});
    fork
      cmd({8'h01, 8'h00});
      begin
        // Pulse low inside the data byte, back high before deselect
        repeat (100) @(posedge core_clk);
        wpN <= 1'b0;
        repeat (10) @(posedge core_clk);
        wpN <= 1'b1;
      end
    join
    status({8'h8D, 8'h80});
    wpN <= 1'b1;
    wrsr(8'h00);
    status({8'h8D, 8'h00});
    repeat (10) @(posedge core_clk);
    check(8'(expq.size()), 8'h00);
    complete_run();
  end
endmodule
bind spe_eeprom_front spe_front_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .core_clk(core_clk), .resetn(resetn), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
  .holdN(holdN), .soOut(soOut), .soOe(soOe), .writeBusy(writeBusy));
`default_nettype wire
